// >>> logic/apfc_pkg.sv
// Package: offsets, field positions, reset values and codes for apfc
package apfc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [6:0] SERIAL_FORMAT_CONFIG_OFS = 7'h04;
  localparam logic [6:0] MISCELLANEOUS_CONFIG_OFS = 7'h05;
  localparam logic [6:0] HELD_FIRST_OFS           = 7'h0f;
  localparam logic [6:0] HELD_LAST_OFS            = 7'h1b;
  localparam int         HELD_COUNT               = 13;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SERIAL_FORMAT_RESET = 8'h40;
  localparam logic [7:0] MISC_RESET          = 8'h00;
  localparam logic [7:0] MISC_RSVD_MASK      = 8'hdf;

  // ---------------------------------------------------------------
  // Field positions, serial_format_config
  // ---------------------------------------------------------------
  localparam int FMT_SEL_LSB     = 6;
  localparam int ADC_SL_LSB      = 4;
  localparam int DAC_SL_LSB      = 2;
  localparam int AUX_RJ16_BIT    = 1;
  localparam int MAIN_RJ16_BIT   = 0;

  // ---------------------------------------------------------------
  // Field positions, miscellaneous_config
  // ---------------------------------------------------------------
  localparam int EXT_ADC_CLK_BIT = 7;
  localparam int RECOVERED_MCLK_OUT_TRI_BIT    = 6;
  localparam int HOLD_BIT        = 4;
  localparam int ROLLOFF_BIT     = 3;
  localparam int HPF_HOLD_BIT    = 2;
  localparam int MAIN_MS_BIT     = 1;
  localparam int AUX_MS_BIT      = 0;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RATE_NONE  = 2'h0;
  localparam logic [1:0] RATE_32K   = 2'h1;
  localparam logic [1:0] RATE_44K1  = 2'h2;
  localparam logic [1:0] RATE_48K   = 2'h3;
  localparam logic [1:0] FMT_LJ     = 2'h0;
  localparam logic [1:0] FMT_I2S    = 2'h1;
  localparam logic [1:0] FMT_RJ     = 2'h2;
  localparam logic [1:0] SL_COMMON  = 2'h0;
  localparam logic [1:0] SL_VAR1    = 2'h1;
  localparam logic [1:0] SL_VAR2    = 2'h2;

  typedef enum logic [2:0] {
    APFC_LEFT_JUST,
    APFC_I2S,
    APFC_RIGHT_JUST,
    APFC_ONE_LINE_1,
    APFC_ONE_LINE_2,
    APFC_UNDEFINED
  } apfc_format_t;

  // ---------------------------------------------------------------
  // Clock divider timing
  // ---------------------------------------------------------------
  localparam logic [3:0] BITCLK_HALF_CYCLES  = 4'h4;
  localparam logic [5:0] FRAME_HALF_BITCLKS  = 6'h20;

endpackage : apfc_pkg

// >>> logic/apfc_top.sv
// Serial audio port format and configuration control block
`timescale 1ns/10ps
module apfc_top (
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_resetn,
  // Register port
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [6:0]            i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  // De-emphasis controls held elsewhere
  input  wire logic                  i_converter_deemph_enable,
  input  wire logic                  i_receiver_deemph_enable,
  input  wire logic                  i_forced_lock_enable,
  input  wire logic [1:0]            i_manual_deemph_rate,
  input  wire logic [1:0]            i_detected_rate,
  input  wire logic                  i_cs_emphasis,
  output logic      [1:0]            o_converter_deemph_rate,
  output logic      [1:0]            o_receiver_deemph_rate,
  // Format and filter controls
  output apfc_pkg::apfc_format_t     o_adc_format,
  output apfc_pkg::apfc_format_t     o_dac_format,
  output apfc_pkg::apfc_format_t     o_aux_format,
  output logic                       o_aux_port_rj_short_words,
  output logic                       o_main_port_rj_short_words,
  output logic                       o_interp_rolloff_sel,
  output logic                       o_highpass_hold,
  // Held register values in use
  output logic [8*apfc_pkg::HELD_COUNT-1:0] o_held_applied,
  // Recovered master clock pin
  input  wire logic                  i_recovered_mclk,
  output logic                       o_recovered_mclk_out,
  output logic                       o_recovered_mclk_oe_n,
  // Main port clock pins
  input  wire logic                  i_main_port_bitclk,
  output logic                       o_main_port_bitclk,
  output logic                       o_main_port_bitclk_oe_n,
  input  wire logic                  i_main_port_frameclk,
  output logic                       o_main_port_frameclk,
  output logic                       o_main_port_frameclk_oe_n,
  // Aux port clock pins
  input  wire logic                  i_aux_port_bitclk,
  output logic                       o_aux_port_bitclk,
  output logic                       o_aux_port_bitclk_oe_n,
  input  wire logic                  i_aux_port_frameclk,
  output logic                       o_aux_port_frameclk,
  output logic                       o_aux_port_frameclk_oe_n,
  // External ADC bit clock
  output logic                       o_ext_adc_bitclk
);
  import apfc_pkg::*;
  logic [7:0] fmt_reg;
  logic [7:0] misc_reg;
  logic [7:0] held_stage [HELD_COUNT];
  logic [7:0] held_apply [HELD_COUNT];
  logic       hold_on;
  logic       in_held;
  logic [3:0] held_idx;
  logic [3:0] bit_cnt_reg;
  logic [5:0] frm_cnt_reg;
  logic       gen_bit_reg;
  logic       gen_frm_reg;
  logic [1:0] main_bit_sync;
  logic [1:0] aux_bit_sync;
  logic       recovered_mclk_out_meta_reg;
  logic       main_bit_now;
  logic       aux_bit_now;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Held window decode
  assign in_held  = (i_reg_addr >= HELD_FIRST_OFS) &&
                    (i_reg_addr <= HELD_LAST_OFS);
  assign held_idx = 4'(i_reg_addr - HELD_FIRST_OFS);
  assign hold_on  = misc_reg[HOLD_BIT];

  // Configuration writes; reserved misc bit never stores
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      fmt_reg  <= SERIAL_FORMAT_RESET;
      misc_reg <= MISC_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == SERIAL_FORMAT_CONFIG_OFS) begin
        fmt_reg <= i_reg_wdata;
      end
      if (i_reg_addr == MISCELLANEOUS_CONFIG_OFS) begin
        misc_reg <= i_reg_wdata & MISC_RSVD_MASK;
      end
    end
  end

  // Staged copies always take the write
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      for (int k = 0; k < HELD_COUNT; k++) begin
        held_stage[k] <= 8'h00;
      end
    end else if (i_reg_wr && in_held) begin
      held_stage[held_idx] <= i_reg_wdata;
    end
  end

  // Applied copies track staging unless held; release applies all at once
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      for (int k = 0; k < HELD_COUNT; k++) begin
        held_apply[k] <= 8'h00;
      end
    end else if (!hold_on) begin
      for (int k = 0; k < HELD_COUNT; k++) begin
        held_apply[k] <= held_stage[k];
      end
    end
  end

  // Flatten the applied values
  always_comb begin
    o_held_applied = '0;
    for (int k = 0; k < HELD_COUNT; k++) begin
      o_held_applied[8*k +: 8] = held_apply[k];
    end
  end

  // Read data, unmapped offsets read zero
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (i_reg_addr == SERIAL_FORMAT_CONFIG_OFS) begin
        o_reg_rdata <= fmt_reg;
      end else if (i_reg_addr == MISCELLANEOUS_CONFIG_OFS) begin
        o_reg_rdata <= misc_reg;
      end else if (in_held) begin
        o_reg_rdata <= held_stage[held_idx];
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // De-emphasis selection
  // ---------------------------------------------------------------
  // Auto rate is already limited to the three filter rates by its code
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_converter_deemph_rate <= RATE_NONE;
      o_receiver_deemph_rate  <= RATE_NONE;
    end else begin
      if (!i_converter_deemph_enable) begin
        o_converter_deemph_rate <= RATE_NONE;
      end else if (i_forced_lock_enable) begin
        o_converter_deemph_rate <= i_manual_deemph_rate;
      end else begin
        o_converter_deemph_rate <= i_detected_rate;
      end
      if (!i_receiver_deemph_enable || !i_cs_emphasis) begin
        o_receiver_deemph_rate <= RATE_NONE;
      end else if (i_forced_lock_enable) begin
        o_receiver_deemph_rate <= i_manual_deemph_rate;
      end else begin
        o_receiver_deemph_rate <= i_detected_rate;
      end
    end
  end

  // ---------------------------------------------------------------
  // Format decode
  // ---------------------------------------------------------------
  function automatic apfc_format_t common_fmt(input logic [1:0] f);
    case (f)
      FMT_LJ:  common_fmt = APFC_LEFT_JUST;
      FMT_I2S: common_fmt = APFC_I2S;
      FMT_RJ:  common_fmt = APFC_RIGHT_JUST;
      default: common_fmt = APFC_UNDEFINED;
    endcase
  endfunction

  function automatic apfc_format_t path_fmt(input logic [1:0] sl,
                                            input logic [1:0] f);
    case (sl)
      SL_COMMON: path_fmt = common_fmt(f);
      SL_VAR1:   path_fmt = APFC_ONE_LINE_1;
      SL_VAR2:   path_fmt = APFC_ONE_LINE_2;
      default:   path_fmt = APFC_UNDEFINED;
    endcase
  endfunction

  // Registered so format changes land on a clean edge
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_adc_format <= APFC_I2S;
      o_dac_format <= APFC_I2S;
      o_aux_format <= APFC_I2S;
    end else begin
      o_adc_format <= path_fmt(fmt_reg[ADC_SL_LSB +: 2],
                               fmt_reg[FMT_SEL_LSB +: 2]);
      o_dac_format <= path_fmt(fmt_reg[DAC_SL_LSB +: 2],
                               fmt_reg[FMT_SEL_LSB +: 2]);
      o_aux_format <= common_fmt(fmt_reg[FMT_SEL_LSB +: 2]);
    end
  end

  // Word length and filter flags straight from their bits
  assign o_aux_port_rj_short_words  = fmt_reg[AUX_RJ16_BIT];
  assign o_main_port_rj_short_words = fmt_reg[MAIN_RJ16_BIT];
  assign o_interp_rolloff_sel       = misc_reg[ROLLOFF_BIT];
  assign o_highpass_hold            = misc_reg[HPF_HOLD_BIT];

  // ---------------------------------------------------------------
  // Recovered clock pin
  // ---------------------------------------------------------------
  // Two-flop retime; only fit for clocks well below the core rate
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      recovered_mclk_out_meta_reg         <= 1'b0;
      o_recovered_mclk_out  <= 1'b0;
      o_recovered_mclk_oe_n <= 1'b0;
    end else begin
      recovered_mclk_out_meta_reg         <= i_recovered_mclk;
      o_recovered_mclk_out  <= recovered_mclk_out_meta_reg;
      o_recovered_mclk_oe_n <= misc_reg[RECOVERED_MCLK_OUT_TRI_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Port clock generation and pin direction
  // ---------------------------------------------------------------
  // One divider serves both ports; they share a master rate
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      bit_cnt_reg <= 4'h0;
      frm_cnt_reg <= 6'h00;
      gen_bit_reg <= 1'b0;
      gen_frm_reg <= 1'b0;
    end else if (bit_cnt_reg == BITCLK_HALF_CYCLES - 4'h1) begin
      bit_cnt_reg <= 4'h0;
      gen_bit_reg <= ~gen_bit_reg;
      if (gen_bit_reg) begin
        if (frm_cnt_reg == FRAME_HALF_BITCLKS - 6'h01) begin
          frm_cnt_reg <= 6'h00;
          gen_frm_reg <= ~gen_frm_reg; // Frame flips on a falling bit edge
        end else begin
          frm_cnt_reg <= frm_cnt_reg + 6'h01;
        end
      end
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Bit clock pins pass two flops; frame pins feed nothing in this block
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      main_bit_sync <= 2'b00;
      aux_bit_sync  <= 2'b00;
    end else begin
      main_bit_sync <= {main_bit_sync[0], i_main_port_bitclk};
      aux_bit_sync  <= {aux_bit_sync[0], i_aux_port_bitclk};
    end
  end

  // Direction follows the master bits; low enable means driving
  assign o_main_port_bitclk        = gen_bit_reg;
  assign o_main_port_frameclk      = gen_frm_reg;
  assign o_main_port_bitclk_oe_n   = ~misc_reg[MAIN_MS_BIT];
  assign o_main_port_frameclk_oe_n = ~misc_reg[MAIN_MS_BIT];
  assign o_aux_port_bitclk         = gen_bit_reg;
  assign o_aux_port_frameclk       = gen_frm_reg;
  assign o_aux_port_bitclk_oe_n    = ~misc_reg[AUX_MS_BIT];
  assign o_aux_port_frameclk_oe_n  = ~misc_reg[AUX_MS_BIT];

  // Bit clock seen at each port, own or supplied by the far side
  assign main_bit_now = misc_reg[MAIN_MS_BIT] ? gen_bit_reg
                                              : main_bit_sync[1];
  assign aux_bit_now  = misc_reg[AUX_MS_BIT]  ? gen_bit_reg
                                              : aux_bit_sync[1];

  // External ADC bit clock source
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_ext_adc_bitclk <= 1'b0;
    end else begin
      o_ext_adc_bitclk <= misc_reg[EXT_ADC_CLK_BIT] ? main_bit_now
                                                    : aux_bit_now;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  conv_auto_rate_a: assert property (
    i_converter_deemph_enable && !i_forced_lock_enable
    |=> o_converter_deemph_rate == $past(i_detected_rate))
    else $error("converter rate not from detected rate");
  conv_manual_rate_a: assert property (
    i_converter_deemph_enable && i_forced_lock_enable
    |=> o_converter_deemph_rate == $past(i_manual_deemph_rate))
    else $error("converter rate not from manual field");
  rcv_emph_follow_a: assert property (
    i_receiver_deemph_enable && i_cs_emphasis && !i_forced_lock_enable
    |=> o_receiver_deemph_rate == $past(i_detected_rate))
    else $error("receiver rate not from detected rate");
  rcv_disable_a: assert property (
    !i_receiver_deemph_enable |=> o_receiver_deemph_rate == RATE_NONE)
    else $error("receiver de-emphasis active while disabled");
  fmt_write_a: assert property (
    i_reg_wr && i_reg_addr == SERIAL_FORMAT_CONFIG_OFS &&
    i_reg_wdata[ADC_SL_LSB +: 2] == SL_COMMON &&
    i_reg_wdata[FMT_SEL_LSB +: 2] == FMT_RJ
    |=> ##1 o_adc_format == APFC_RIGHT_JUST)
    else $error("format write not reflected on ADC path");
  adc_line_a: assert property (
    fmt_reg[ADC_SL_LSB +: 2] == SL_VAR2
    |=> o_adc_format == APFC_ONE_LINE_2)
    else $error("ADC single-line variant 2 not selected");
  dac_line_a: assert property (
    fmt_reg[DAC_SL_LSB +: 2] == SL_VAR1
    |=> o_dac_format == APFC_ONE_LINE_1)
    else $error("DAC single-line variant 1 not selected");
  hold_keep_a: assert property (
    hold_on && $past(hold_on) |-> $stable(o_held_applied))
    else $error("held values changed during update hold");
  hold_release_a: assert property (
    !hold_on |=> held_apply[0] == $past(held_stage[0]))
    else $error("staged value not applied after release");
  recovered_mclk_out_tri_a: assert property (
    $rose(misc_reg[RECOVERED_MCLK_OUT_TRI_BIT]) |=> o_recovered_mclk_oe_n)
    else $error("recovered clock not floated");
  main_dir_a: assert property (
    !misc_reg[MAIN_MS_BIT] |-> o_main_port_bitclk_oe_n &&
    o_main_port_frameclk_oe_n)
    else $error("main port pins driven in slave mode");
  bitclk_period_a: assert property (
    $rose(gen_bit_reg) |=> !$rose(gen_bit_reg) [*7] ##1 $rose(gen_bit_reg))
    else $error("generated bit clock period wrong");
  ext_clk_src_a: assert property (
    misc_reg[EXT_ADC_CLK_BIT] && $stable(misc_reg)
    |=> o_ext_adc_bitclk == $past(main_bit_now))
    else $error("external ADC clock source wrong");

  cov_forced_c:  cover property (i_forced_lock_enable &&
                                 o_converter_deemph_rate == RATE_48K);
  cov_release_c: cover property ($fell(hold_on));
  cov_master_c:  cover property ($rose(gen_frm_reg) &&
                                 misc_reg[AUX_MS_BIT]);

endmodule : apfc_top

// >>> tb/apfc_audio_proc.sv
// Far-side audio processor model: clocks for one slave serial port
`timescale 1ns/10ps
module apfc_audio_proc #(
  parameter int HALF = 3
) (
  input  wire logic i_core_clk,
  output logic      o_bitclk,
  output logic      o_frameclk
);
  int cnt  = 0;
  int bits = 0;

  // Start low so the port sees clean edges from the first cycle
  initial begin
    o_bitclk = 1'b0;
    o_frameclk = 1'b0;
  end

  // Frame clock never stops: a slave port loses framing without it
  always @(negedge i_core_clk) begin
    cnt = cnt + 1;
    if (cnt == HALF) begin
      cnt = 0;
      if (o_bitclk) begin
        bits = bits + 1;
        if (bits == 32) begin
          bits = 0;
          o_frameclk <= ~o_frameclk;
        end
      end
      o_bitclk <= ~o_bitclk;
    end
  end
endmodule // apfc_audio_proc

// >>> tb/tb.sv
// Self-checking bench for the audio port format control block
`timescale 1ns/10ps
module tb;
  import apfc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic         clk = 1'b0;
  logic         resetn, wr, rd, cde, rde, fle, cse, recovered_mclk_out, pr;
  logic [6:0]   addr;
  logic [7:0]   wdata, rdata, v;
  logic [1:0]   mrate, drate, crate, rrate, e;
  apfc_format_t adcf, dacf, auxf;
  logic         auxrj, mainrj, roll, hpf, recovered_mclk_out_o, recovered_mclk_out_oe_n, ext;
  logic         mbo, mbo_n, mfo, mfo_n, abo, abo_n, afo, afo_n;
  logic         pmb, pmf, pab, paf;
  wire          mb, mf, ab, af;
  logic [103:0] held, stg_m, app_m;
  int           bad_count, n_compared, cyc, n_ext, n_mb, n_mf, n_ab, n_af;

  always #10 clk = ~clk;

  // Pin level: design drives when its enable is low, else the far side
  assign mb = mbo_n ? pmb : mbo;
  assign mf = mfo_n ? pmf : mfo;
  assign ab = abo_n ? pab : abo;
  assign af = afo_n ? paf : afo;

  apfc_top dut (
    .i_core_clk(clk), .i_resetn(resetn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_converter_deemph_enable(cde), .i_receiver_deemph_enable(rde),
    .i_forced_lock_enable(fle), .i_manual_deemph_rate(mrate),
    .i_detected_rate(drate), .i_cs_emphasis(cse),
    .o_converter_deemph_rate(crate), .o_receiver_deemph_rate(rrate),
    .o_adc_format(adcf), .o_dac_format(dacf), .o_aux_format(auxf),
    .o_aux_port_rj_short_words(auxrj),
    .o_main_port_rj_short_words(mainrj), .o_interp_rolloff_sel(roll),
    .o_highpass_hold(hpf), .o_held_applied(held),
    .i_recovered_mclk(recovered_mclk_out), .o_recovered_mclk_out(recovered_mclk_out_o),
    .o_recovered_mclk_oe_n(recovered_mclk_out_oe_n),
    .i_main_port_bitclk(mb), .o_main_port_bitclk(mbo),
    .o_main_port_bitclk_oe_n(mbo_n), .i_main_port_frameclk(mf),
    .o_main_port_frameclk(mfo), .o_main_port_frameclk_oe_n(mfo_n),
    .i_aux_port_bitclk(ab), .o_aux_port_bitclk(abo),
    .o_aux_port_bitclk_oe_n(abo_n), .i_aux_port_frameclk(af),
    .o_aux_port_frameclk(afo), .o_aux_port_frameclk_oe_n(afo_n),
    .o_ext_adc_bitclk(ext)
  );

  // Main side slower than aux so the external clock source is visible
  apfc_audio_proc #(.HALF(7)) main_far (
    .i_core_clk(clk), .o_bitclk(pmb), .o_frameclk(pmf));
  apfc_audio_proc #(.HALF(3)) aux_far (
    .i_core_clk(clk), .o_bitclk(pab), .o_frameclk(paf));

  // Edge counters for the clock pins
  always @(posedge ext) n_ext++;
  always @(posedge mb) n_mb++;
  always @(posedge ab) n_ab++;
  always @(mf) n_mf++;
  always @(af) n_af++;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [103:0] got, input logic [103:0] x);
    n_compared++;
    if (got !== x) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, x);
    end
  endtask

  task automatic chk_fmt(input apfc_format_t got, input apfc_format_t x);
    n_compared++;
    if (got !== x) begin
      bad_count++;
      $display("ERROR %0t: format %s expected %s", $time, got.name, x.name);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic do_reset;
    @(negedge clk);
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(rdata, x);
  endtask

  task automatic measure(input int n);
    {n_ext, n_mb, n_ab, n_mf, n_af} = '0;
    repeat (n) @(negedge clk);
  endtask

  // Expected format from common field and single-line field
  function automatic apfc_format_t fmt_of(input logic [1:0] c, s);
    if (s == 2'h1) return APFC_ONE_LINE_1;
    if (s == 2'h2) return APFC_ONE_LINE_2;
    if (s == 2'h3 || c == 2'h3) return APFC_UNDEFINED;
    if (c == 2'h0) return APFC_LEFT_JUST;
    return (c == 2'h1) ? APFC_I2S : APFC_RIGHT_JUST;
  endfunction

  // Ceiling well above the roughly 1100 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {resetn, wr, rd, cde, rde, fle, cse, recovered_mclk_out} = '0;
    {addr, wdata, mrate, drate} = '0;
    void'($urandom(32'h135fbba6));
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    rd_chk(SERIAL_FORMAT_CONFIG_OFS, SERIAL_FORMAT_RESET);
    rd_chk(MISCELLANEOUS_CONFIG_OFS, MISC_RESET);
    chk_fmt(dacf, APFC_I2S);
    chk({mbo_n, abo_n, recovered_mclk_out_oe_n}, 3'h6);
    wr_reg(7'h7e, 8'hff);
    rd_chk(7'h7e, 8'h00);
    done("reset");
    // Every legal format and single-line code; software avoids code 11
    for (int i = 0; i < 64; i++) begin
      if (i[5:4] == 2'h3 || i[3:2] == 2'h3 || i[1:0] == 2'h3) begin
        continue;
      end
      v = {i[5:0], 2'($urandom)};
      wr_reg(SERIAL_FORMAT_CONFIG_OFS, v);
      @(negedge clk);
      chk_fmt(adcf, fmt_of(v[7:6], v[5:4]));
      chk_fmt(dacf, fmt_of(v[7:6], v[3:2]));
      chk_fmt(auxf, fmt_of(v[7:6], 2'h0));
      chk({auxrj, mainrj}, v[1:0]);
    end
    done("formats");
    for (int i = 0; i < 64; i++) begin
      {cde, rde, fle, cse, mrate, drate} = 8'($urandom);
      pr = recovered_mclk_out;
      recovered_mclk_out = 1'($urandom);
      @(negedge clk);
      e = fle ? mrate : drate;
      chk(crate, cde ? e : 2'h0);
      chk(rrate, (rde && cse) ? e : 2'h0);
      chk(recovered_mclk_out_o, pr);
    end
    done("deemphasis");
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom) & 8'hef;
      wr_reg(MISCELLANEOUS_CONFIG_OFS, v);
      @(negedge clk);
      chk(recovered_mclk_out_oe_n, v[RECOVERED_MCLK_OUT_TRI_BIT]);
      chk({roll, hpf}, {v[ROLLOFF_BIT], v[HPF_HOLD_BIT]});
      chk({mbo_n, mfo_n}, {2{~v[MAIN_MS_BIT]}});
      chk({abo_n, afo_n}, {2{~v[AUX_MS_BIT]}});
      rd_chk(MISCELLANEOUS_CONFIG_OFS, v & MISC_RSVD_MASK);
    end
    done("misc");
    // Slave: aux far clock runs 14 rises in 84 cycles, main only 6
    for (int s = 0; s < 2; s++) begin
      wr_reg(MISCELLANEOUS_CONFIG_OFS, {s[0], 7'h00});
      measure(84);
      chk(n_ext > 10, s == 0);
    end
    wr_reg(MISCELLANEOUS_CONFIG_OFS, 8'h83);
    measure(520);
    chk(n_mb inside {[64:66]}, 1'b1);
    chk(n_mf inside {[2:3]}, 1'b1);
    chk(n_ab inside {[64:66]}, 1'b1);
    chk(n_af inside {[2:3]}, 1'b1);
    chk(n_ext inside {[64:66]}, 1'b1);
    done("clocks");
    wr_reg(MISCELLANEOUS_CONFIG_OFS, 8'h00);
    for (int r = 0; r < 2; r++) begin
      if (r == 1) wr_reg(MISCELLANEOUS_CONFIG_OFS, 8'h10);
      for (int k = 0; k < HELD_COUNT; k++) begin
        v = 8'($urandom);
        stg_m[8*k +: 8] = v;
        wr_reg(HELD_FIRST_OFS + 7'(k), v);
      end
      repeat (2) @(negedge clk);
      if (r == 0) app_m = stg_m;
      chk(held, app_m);
      rd_chk(HELD_LAST_OFS, stg_m[103:96]);
    end
    wr_reg(MISCELLANEOUS_CONFIG_OFS, 8'h00);
    repeat (2) @(negedge clk);
    chk(held, stg_m);
    done("hold");
    do_reset();
    rd_chk(SERIAL_FORMAT_CONFIG_OFS, SERIAL_FORMAT_RESET);
    chk_fmt(adcf, APFC_I2S);
    done("second reset");
    end_of_test();
  end
endmodule // tb
